// File: axi_probe_pkg.sv
// Package with probe layouts, event bundles and widths for the channel event probe
package axi_probe_pkg;

  // ****************************************
  // Probe field positions
  // ****************************************
  localparam int unsigned VALID_BIT = 0;
  localparam int unsigned READY_BIT = 1;
  localparam int unsigned LAST_BIT  = 2;

  // ****************************************
  // Handshake probe codes
  // ****************************************
  localparam logic [1:0] ADDR_DONE_CODE  = 2'h3;
  localparam logic [2:0] LAST_BEAT_CODE  = 3'h7;
  localparam logic [2:0] BEAT_CODE       = 3'h3;
  localparam logic [1:0] RESP_DONE_CODE  = 2'h3;

  // ****************************************
  // Reset values and widths
  // ****************************************
  localparam int unsigned CNT_W         = 16;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic        FLAG_RST      = 1'b0;

  // Combined per-channel handshake probes
  typedef struct packed {
    logic [1:0] rd_addr;
    logic [2:0] rd_data;
    logic [1:0] wr_addr;
    logic [2:0] wr_data;
    logic [1:0] wr_resp;
  } probe_bus_t;

  // Per-cycle decoded events
  typedef struct packed {
    logic rd_addr_busy;
    logic rd_addr_done;
    logic rd_last_beat;
    logic rd_beat;
    logic wr_addr_busy;
    logic wr_addr_done;
    logic wr_last_beat;
    logic wr_beat;
    logic wr_beat_start;
    logic wr_resp;
    logic no_wr_resp;
  } event_bus_t;

endpackage : axi_probe_pkg

// File: axi_channel_event_probe.sv
// Passive AXI channel handshake probe and event decoder
// Contract
// - Flag write response whenever response valid and ready are both high.
// - Report no write response when the response channel sees no handshake.
// - Read address probe: valid bit 0, ready bit 1.
// - Read data probe: valid bit 0, ready bit 1, last bit 2.
// - Write address probe: valid bit 0, ready bit 1.
// - Write data probe: valid bit 0, ready bit 1, last bit 2.
// - Write response probe: valid bit 0, ready bit 1.
// - Read address command ends when its probe equals 11.
// - Last read beat ends when read data probe equals 111.
// - Non-last read beat ends when read data probe equals 011.
// - Write address command ends when its probe equals 11.
// - Last write beat ends when write data probe equals 111.
// - Non-last write beat ends when write data probe equals 011.
// - Each channel's handshake bits share one probe so triggers can be ORed.
// - Write data group holds valid, ready, last, data and byte strobes.
// - Response group holds valid, ready, ID, code and a response count.
// - Write beat start: both high now, one of them low last cycle.
// - Read address command starts on valid, ends on valid and ready.
`timescale 1ns/1ps

module axi_channel_event_probe
  import axi_probe_pkg::*;
#(
  parameter int unsigned DATA_W = 32, // Write data width
  parameter int unsigned ID_W   = 4   // Transaction ID width
) (
  input  wire logic                clk_i,         // Monitored interface clock
  input  wire logic                rst_n_i,       // Asynchronous reset, active low
  input  wire logic                arvalid_i,     // Read address valid
  input  wire logic                arready_i,     // Read address ready
  input  wire logic                rvalid_i,      // Read data valid
  input  wire logic                rready_i,      // Read data ready
  input  wire logic                rlast_i,       // Read data last
  input  wire logic                awvalid_i,     // Write address valid
  input  wire logic                awready_i,     // Write address ready
  input  wire logic                wvalid_i,      // Write data valid
  input  wire logic                wready_i,      // Write data ready
  input  wire logic                wlast_i,       // Write data last
  input  wire logic [DATA_W-1:0]   wdata_i,       // Write data
  input  wire logic [DATA_W/8-1:0] wstrb_i,       // Write byte strobes
  input  wire logic                bvalid_i,      // Response valid
  input  wire logic                bready_i,      // Response ready
  input  wire logic [ID_W-1:0]     bid_i,         // Response ID
  input  wire logic [1:0]          bresp_i,       // Response code
  output logic                     probe_o,       // Combined address-end trigger, registered
  output probe_bus_t               probes_o,      // Per-channel handshake probes
  output event_bus_t               events_o,      // Decoded events, registered
  output logic [DATA_W-1:0]        wdata_o,       // Captured write data
  output logic [DATA_W/8-1:0]      wstrb_o,       // Captured write strobes
  output logic [ID_W-1:0]          bid_o,         // Captured response ID
  output logic [1:0]               bresp_o,       // Captured response code
  output logic [CNT_W-1:0]         resp_cnt_o     // Count of write responses
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    probe_bus_t          probes;
    event_bus_t          events;
    logic                w_both_prev;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic [ID_W-1:0]     bid;
    logic [1:0]          bresp;
    logic [CNT_W-1:0]    resp_cnt;
    logic                trig;
  } state_t;

  state_t     cur;
  state_t     next_cur;
  probe_bus_t raw;

  // Pack each channel's handshake bits into one probe; inputs are read only
  always_comb begin
    raw                           = '0;
    raw.rd_addr[VALID_BIT]        = arvalid_i;
    raw.rd_addr[READY_BIT]        = arready_i;
    raw.rd_data[VALID_BIT]        = rvalid_i;
    raw.rd_data[READY_BIT]        = rready_i;
    raw.rd_data[LAST_BIT]         = rlast_i;
    raw.wr_addr[VALID_BIT]        = awvalid_i;
    raw.wr_addr[READY_BIT]        = awready_i;
    raw.wr_data[VALID_BIT]        = wvalid_i;
    raw.wr_data[READY_BIT]        = wready_i;
    raw.wr_data[LAST_BIT]         = wlast_i;
    raw.wr_resp[VALID_BIT]        = bvalid_i;
    raw.wr_resp[READY_BIT]        = bready_i;
  end

  // ****************************************
  // Event decode and capture
  // ****************************************
  // Decode from the combined probes; write beat start also uses last cycle's write handshake
  always_comb begin
    next_cur        = cur;
    next_cur.probes = raw;
    next_cur.events.rd_addr_busy  = raw.rd_addr[VALID_BIT] &&
                                    !raw.rd_addr[READY_BIT];
    next_cur.events.rd_addr_done  = (raw.rd_addr == ADDR_DONE_CODE);
    next_cur.events.rd_last_beat  = (raw.rd_data == LAST_BEAT_CODE);
    next_cur.events.rd_beat       = (raw.rd_data == BEAT_CODE);
    next_cur.events.wr_addr_busy  = raw.wr_addr[VALID_BIT] &&
                                    !raw.wr_addr[READY_BIT];
    next_cur.events.wr_addr_done  = (raw.wr_addr == ADDR_DONE_CODE);
    next_cur.events.wr_last_beat  = (raw.wr_data == LAST_BEAT_CODE);
    next_cur.events.wr_beat       = (raw.wr_data == BEAT_CODE);
    next_cur.w_both_prev          = wvalid_i && wready_i;
    next_cur.events.wr_beat_start = wvalid_i && wready_i &&
                                    !cur.w_both_prev;
    next_cur.events.wr_resp       = (raw.wr_resp == RESP_DONE_CODE);
    next_cur.events.no_wr_resp    = (raw.wr_resp != RESP_DONE_CODE);
    // Combined trigger: read or write address command end
    next_cur.trig                 = (raw.rd_addr == ADDR_DONE_CODE) ||
                                    (raw.wr_addr == ADDR_DONE_CODE);
    // Write data group captured on each accepted beat
    if (wvalid_i && wready_i) begin
      next_cur.wdata = wdata_i;
      next_cur.wstrb = wstrb_i;
    end
    // Response group captured and counted on each handshake
    if (raw.wr_resp == RESP_DONE_CODE) begin
      next_cur.bid      = bid_i;
      next_cur.bresp    = bresp_i;
      next_cur.resp_cnt = cur.resp_cnt + CNT_W'(1);
    end
  end

  // State register; sampled once per rising edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur                   <= '0;
      cur.resp_cnt          <= CNT_RST;
      cur.events.no_wr_resp <= ~FLAG_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registered trigger, so the trigger line carries no decode glitch
  assign probe_o    = cur.trig;
  assign probes_o   = cur.probes;
  assign events_o   = cur.events;
  assign wdata_o    = cur.wdata;
  assign wstrb_o    = cur.wstrb;
  assign bid_o      = cur.bid;
  assign bresp_o    = cur.bresp;
  assign resp_cnt_o = cur.resp_cnt;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_resp_hs;
    bvalid_i && bready_i;
  endsequence

  sequence s_w_rise;
    !(wvalid_i && wready_i) ##1 (wvalid_i && wready_i);
  endsequence

  // Single-cycle handshake shapes, one per channel and beat kind
  sequence s_ar_hs;
    arvalid_i && arready_i;
  endsequence

  sequence s_ar_wait;
    arvalid_i && !arready_i;
  endsequence

  sequence s_aw_hs;
    awvalid_i && awready_i;
  endsequence

  sequence s_aw_wait;
    awvalid_i && !awready_i;
  endsequence

  sequence s_r_last;
    rvalid_i && rready_i && rlast_i;
  endsequence

  sequence s_r_mid;
    rvalid_i && rready_i && !rlast_i;
  endsequence

  sequence s_w_hs;
    wvalid_i && wready_i;
  endsequence

  sequence s_w_last;
    wvalid_i && wready_i && wlast_i;
  endsequence

  sequence s_w_mid;
    wvalid_i && wready_i && !wlast_i;
  endsequence

  // Address command that waits at least one cycle before it is accepted
  sequence s_ar_cmd;
    s_ar_wait ##1 s_ar_hs;
  endsequence

  sequence s_aw_cmd;
    s_aw_wait ##1 s_aw_hs;
  endsequence

  AST_RESP_EVT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_resp_hs |=> events_o.wr_resp && !events_o.no_wr_resp)
    else $error("Response handshake not flagged");

  AST_NO_RESP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(bvalid_i && bready_i) |=> events_o.no_wr_resp && !events_o.wr_resp)
    else $error("Idle response channel not reported");

  AST_RESP_CNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_resp_hs |=> resp_cnt_o == $past(resp_cnt_o) + CNT_W'(1))
    else $error("Response count did not advance");

  AST_RD_PROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o.rd_data == {$past(rlast_i), $past(rready_i), $past(rvalid_i)})
    else $error("Read data probe bit order wrong");

  AST_AR_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 events_o.rd_addr_done == ($past(arvalid_i) && $past(arready_i)))
    else $error("Read address end mismatch");

  AST_RD_BEATS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rvalid_i && rready_i) |=> (events_o.rd_beat ^ events_o.rd_last_beat)
      && (events_o.rd_last_beat == $past(rlast_i)))
    else $error("Read beat classification wrong");

  AST_WR_BEATS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wvalid_i && wready_i) |=> (events_o.wr_beat ^ events_o.wr_last_beat)
      && (events_o.wr_last_beat == $past(wlast_i)))
    else $error("Write beat classification wrong");

  AST_W_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_w_rise |=> events_o.wr_beat_start)
    else $error("Write beat start missed");

  AST_W_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wvalid_i && wready_i) [*2] |=> !events_o.wr_beat_start)
    else $error("Write beat start on held handshake");

  AST_TRIG_OR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (awvalid_i && awready_i) |=> probe_o && events_o.wr_addr_done)
    else $error("Combined address trigger missed");

  // Probe layouts: last (data probes only), ready and valid from bit 2 down to bit 0
  AST_AR_PROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o.rd_addr == {$past(arready_i), $past(arvalid_i)})
    else $error("Read address probe bit order wrong");

  AST_AW_PROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o.wr_addr == {$past(awready_i), $past(awvalid_i)})
    else $error("Write address probe bit order wrong");

  AST_W_PROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o.wr_data == {$past(wlast_i), $past(wready_i), $past(wvalid_i)})
    else $error("Write data probe bit order wrong");

  AST_B_PROBE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o.wr_resp == {$past(bready_i), $past(bvalid_i)})
    else $error("Response probe bit order wrong");

  AST_ALL_PROBES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 probes_o == {$past(arready_i), $past(arvalid_i), $past(rlast_i), $past(rready_i),
                     $past(rvalid_i), $past(awready_i), $past(awvalid_i), $past(wlast_i),
                     $past(wready_i), $past(wvalid_i), $past(bready_i), $past(bvalid_i)})
    else $error("Probe bus is not the handshake bits of the cycle before");

  // Read data beats: last and non-last differ in the last bit only
  AST_R_LAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r_last |=> events_o.rd_last_beat && !events_o.rd_beat)
    else $error("Last read beat not flagged");

  AST_R_MID: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r_mid |=> events_o.rd_beat && !events_o.rd_last_beat)
    else $error("Non-last read beat not flagged");

  AST_R_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(rvalid_i && rready_i) |=> !events_o.rd_beat && !events_o.rd_last_beat)
    else $error("Read beat flagged without a handshake");

  // Write data beats, including the start qualifier
  AST_W_LAST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_w_last |=> events_o.wr_last_beat && !events_o.wr_beat)
    else $error("Last write beat not flagged");

  AST_W_MID: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_w_mid |=> events_o.wr_beat && !events_o.wr_last_beat)
    else $error("Non-last write beat not flagged");

  AST_W_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wvalid_i && wready_i) |=> !events_o.wr_beat && !events_o.wr_last_beat
      && !events_o.wr_beat_start)
    else $error("Write beat flagged without a handshake");

  // Address commands: busy while waiting, done in the accepting cycle
  AST_AR_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ar_wait |=> events_o.rd_addr_busy && !events_o.rd_addr_done)
    else $error("Waiting read address command not marked busy");

  AST_AR_CMD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ar_cmd |=> events_o.rd_addr_done && !events_o.rd_addr_busy)
    else $error("Read address command did not end on acceptance");

  AST_AR_TRIG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ar_hs |=> probe_o && events_o.rd_addr_done)
    else $error("Combined trigger missed a read address end");

  AST_AW_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_aw_wait |=> events_o.wr_addr_busy && !events_o.wr_addr_done)
    else $error("Waiting write address command not marked busy");

  AST_AW_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 events_o.wr_addr_done == ($past(awvalid_i) && $past(awready_i)))
    else $error("Write address end mismatch");

  AST_AW_CMD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_aw_cmd |=> events_o.wr_addr_done && !events_o.wr_addr_busy)
    else $error("Write address command did not end on acceptance");

  AST_TRIG_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(arvalid_i && arready_i) && !(awvalid_i && awready_i) |=> !probe_o)
    else $error("Combined trigger without an address end");

  // Captured groups follow accepted beats and responses, and hold otherwise
  AST_W_DATA: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_w_hs |=> wdata_o == $past(wdata_i) && wstrb_o == $past(wstrb_i))
    else $error("Write data group not captured");

  AST_W_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wvalid_i && wready_i) |=> $stable(wdata_o) && $stable(wstrb_o))
    else $error("Write data group changed without a beat");

  AST_B_DATA: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_resp_hs |=> bid_o == $past(bid_i) && bresp_o == $past(bresp_i))
    else $error("Response group not captured");

  AST_B_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(bvalid_i && bready_i) |=> $stable(resp_cnt_o) && $stable(bid_o) && $stable(bresp_o))
    else $error("Response group changed without a handshake");

  AST_RESP_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_resp_hs ##1 s_resp_hs |=> resp_cnt_o == $past(resp_cnt_o, 2) + CNT_W'(2))
    else $error("Back to back responses miscounted");

endmodule : axi_channel_event_probe

// File: axi_pair_model.sv
// Behavioural model of the monitored AXI manager and subordinate pair
`timescale 1ns/1ps
module axi_pair_model
  import axi_probe_pkg::*;
(
  input  wire logic        clk_i, // Interface clock
  input  wire probe_bus_t  cmd_i, // Handshake bits for the next cycle
  input  wire logic [31:0] wd_i,  // Data to offer; also feeds strobes, ID and code
  output probe_bus_t       hs_o,  // Handshake bits on the bus
  output logic [31:0]      wd_o,  // Write data lines
  output logic [3:0]       ws_o,  // Byte strobe lines
  output logic [5:0]       br_o   // Response ID and code lines
);
  // ****
  // Bus drive
  // ****
  // Change just after each edge; idle lines toggle so stale values never look valid
  initial begin
    {hs_o, wd_o, ws_o, br_o} = '0;
    forever begin
      @(posedge clk_i);
      #2;
      hs_o <= cmd_i;
      {wd_o, ws_o} <= cmd_i.wr_data[0] ? {wd_i, wd_i[3:0]} : ~{wd_o, ws_o};
      br_o <= cmd_i.wr_resp[0] ? wd_i[5:0] : ~br_o;
    end
  end
endmodule : axi_pair_model

// File: axi_channel_event_probe_tb_top.sv
// Self-checking bench for the AXI channel event probe
`timescale 1ns/1ps
module axi_channel_event_probe_tb_top;
  import axi_probe_pkg::*;
  // ****
  // Signals
  // ****
  logic        clk, rst_n, trig;        // Clock, reset, OR trigger
  probe_bus_t  cmd, hs, p1, p2, probes; // Requested, on bus, history, seen
  event_bus_t  events;                  // Decoded events
  logic [31:0] wd, d1, bus_wd, cap_wd, exp_wd;
  logic [3:0]  bus_ws, cap_ws, exp_ws, cap_id;
  logic [5:0]  bus_br, exp_br;
  logic [1:0]  cap_br;
  logic [15:0] cnt, exp_cnt;
  int          bad_count, check_count;

  axi_pair_model u_axi_pair_model (.clk_i(clk), .cmd_i(cmd), .wd_i(wd), .hs_o(hs),
    .wd_o(bus_wd), .ws_o(bus_ws), .br_o(bus_br));
  axi_channel_event_probe u_axi_channel_event_probe (.clk_i(clk), .rst_n_i(rst_n),
    .arvalid_i(hs.rd_addr[0]), .arready_i(hs.rd_addr[1]), .rvalid_i(hs.rd_data[0]),
    .rready_i(hs.rd_data[1]), .rlast_i(hs.rd_data[2]), .awvalid_i(hs.wr_addr[0]),
    .awready_i(hs.wr_addr[1]), .wvalid_i(hs.wr_data[0]), .wready_i(hs.wr_data[1]),
    .wlast_i(hs.wr_data[2]), .wdata_i(bus_wd), .wstrb_i(bus_ws), .bvalid_i(hs.wr_resp[0]),
    .bready_i(hs.wr_resp[1]), .bid_i(bus_br[5:2]), .bresp_i(bus_br[1:0]), .probe_o(trig),
    .probes_o(probes), .events_o(events), .wdata_o(cap_wd), .wstrb_o(cap_ws),
    .bid_o(cap_id), .bresp_o(cap_br), .resp_cnt_o(cnt));

  // Clock at 50 MHz and a run limit
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1_000_000;
    bad_count++;
    stop_test();
  end

  // ****
  // Helpers
  // ****
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Offer v for one cycle and judge the cycle sampled just before
  task automatic step(input logic [11:0] v);
    event_bus_t ev;
    cmd = v;
    wd = {16'hA5A5, wd[15:0] + 16'h0001};
    @(posedge clk);
    #3;
    if (p1.wr_data[1:0] == 2'h3) {exp_wd, exp_ws} = {d1, d1[3:0]};
    if (p1.wr_resp == 2'h3) {exp_cnt, exp_br} = {exp_cnt + 16'h0001, d1[5:0]};
    ev = {p1.rd_addr == 2'h1, p1.rd_addr == 2'h3, p1.rd_data == 3'h7, p1.rd_data == 3'h3,
          p1.wr_addr == 2'h1, p1.wr_addr == 2'h3, p1.wr_data == 3'h7, p1.wr_data == 3'h3,
          p1.wr_data[1:0] == 2'h3 && p2.wr_data[1:0] != 2'h3, p1.wr_resp == 2'h3,
          p1.wr_resp != 2'h3};
    chk("probes", p1, probes);
    chk("trigger", p1.rd_addr == 2'h3 || p1.wr_addr == 2'h3, trig);
    chk("events", ev, events);
    chk("wdata", exp_wd, cap_wd);
    chk("wstrb", exp_ws, cap_ws);
    chk("id code", exp_br, {cap_id, cap_br});
    chk("count", exp_cnt, cnt);
    {p2, p1, d1} = {p1, cmd, wd};
  endtask : step

  // ****
  // Scenarios
  // ****
  task automatic test_reset;
    rst_n = 1'b0;
    cmd = '0;
    repeat (6) @(posedge clk);
    #3;
    chk("reset flags", {1'b0, 12'h000, 11'h001}, {trig, probes, events});
    chk("reset captures", 32'h0000_0000, {cap_ws, cap_id, cap_br, cnt});
    chk("reset wdata", 32'h0000_0000, cap_wd);
    @(posedge clk);
    #2;
    rst_n = 1'b1; // Released with the same lag as the bus drive
    #1;
    {p1, p2, exp_wd, exp_ws, exp_br, exp_cnt} = '0;
    $display("test_reset done");
  endtask : test_reset

  task automatic test_read;
    step(12'h400);
    step(12'h400);
    step(12'hC00);
    step(12'h180);
    step(12'h380);
    step(12'h280);
    step(12'h380);
    step(12'h000);
    $display("test_read done");
  endtask : test_read

  task automatic test_write;
    step(12'h020);
    step(12'h060);
    step(12'h00C);
    step(12'h00C);
    step(12'h01C);
    step(12'h008);
    step(12'h01C);
    step(12'h014);
    step(12'h01C);
    step(12'h000);
    $display("test_write done");
  endtask : test_write

  task automatic test_resp;
    step(12'h001);
    repeat (4) step(12'h003);
    step(12'h002);
    step(12'h000);
    $display("test_resp done");
  endtask : test_resp

  task automatic test_trigger;
    step(12'hC60);
    step(12'hC00);
    step(12'h060);
    step(12'h440);
    step(12'hFFF);
    step(12'h000);
    $display("test_trigger done");
  endtask : test_trigger

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Main sequence, with a reset in mid-run
  initial begin
    rst_n = 1'b0;
    cmd = '0;
    wd = 32'hA5A5_0000;
    bad_count = 0;
    check_count = 0;
    test_reset();
    test_read();
    test_write();
    test_resp();
    test_trigger();
    test_reset();
    test_resp();
    stop_test();
  end
endmodule : axi_channel_event_probe_tb_top
